// [common/pcr_pkg.sv]
package pcr_pkg;

  // register indices, low nibble of the per-port register address
  localparam logic [3:0] ADDR_CONTROL_CONFIG   = 4'h3;
  localparam logic [3:0] ADDR_TIMER_CONFIG     = 4'h4;
  localparam logic [3:0] ADDR_SIG_THRESHOLD    = 4'h5;
  localparam logic [3:0] ADDR_CURRENT_RESULT   = 4'h6;

  // control config field positions
  localparam int CTL_FORCE_POWER_UP  = 15;
  localparam int CTL_END_CLASS       = 14;
  localparam int CTL_SET_CLASS       = 13;
  localparam int CTL_PULLUP_OFF      = 12;
  localparam int CTL_DET_TIMER_OFF   = 11;
  localparam int CTL_FOLDBACK_OFF    = 10;
  localparam int CTL_SOFTSTART_OFF   = 9;
  localparam int CTL_DISCHARGE_OFF   = 8;
  localparam int CTL_DROPOUT_OFF     = 7;
  localparam int CTL_READY_DETECT    = 6;
  localparam int CTL_POWER_AVAIL     = 5;
  localparam int CTL_PD_WAKE_BLOCK   = 4;
  localparam int CTL_SRC_WAKE_BLOCK  = 3;
  localparam int CTL_WAKE_REQUEST    = 2;
  localparam int CTL_HW_PIN_GATE     = 1;
  localparam int CTL_SW_ENABLE       = 0;

  // timer config field positions and widths
  localparam int TMR_FORCE_WAKE_GOOD = 8;
  localparam int TMR_FAULT_LSB       = 6;
  localparam int TMR_OVLD_LSB        = 4;
  localparam int TMR_INRUSH_LSB      = 2;
  localparam int TMR_SIG_BAD         = 1;
  localparam int TMR_SIG_GOOD        = 0;
  localparam int TMR_USED_W          = 9;

  // result register layout
  localparam int RES_DATA_W          = 12;
  localparam int RES_NEW             = 12;
  localparam int RES_MISSED          = 13;
  localparam int THR_W               = 8;

  // reset values
  localparam logic [15:0] CONTROL_RST   = 16'h0000;
  localparam logic [8:0]  TIMER_RST     = 9'h008;
  localparam logic [7:0]  THRESHOLD_RST = 8'h00;

  // selector codes
  localparam logic [1:0] SEL_FOREVER = 2'h3;

  // timer base: one microsecond tick from the 100 MHz clock
  localparam int CLK_PERIOD_NS = 10;
  localparam int TICK_NS       = 1000;
  localparam int TICK_DIV      = TICK_NS / CLK_PERIOD_NS;

  // periods in microseconds as printed
  localparam int FAULT_PERIOD_0_US  = 59900;
  localparam int FAULT_PERIOD_1_US  = 29900;
  localparam int FAULT_PERIOD_2_US  = 15000;
  localparam int FAULT_PERIOD_3_US  = 460;
  localparam int INRUSH_PERIOD_0_US = 3500;
  localparam int INRUSH_PERIOD_1_US = 14000;
  localparam int INRUSH_PERIOD_2_US = 56200;
  localparam int OVERLOAD_DELAY_US  = 1100000;
  localparam int RESTART_DELAY_US   = 551000;

  // fault timer falls this many times faster than it rises
  localparam int FAULT_DOWN_STEP = 8;
  localparam int TIMER_W         = 24;
  localparam int NUM_TIMERS      = 3;
  localparam int T_INRUSH        = 0;
  localparam int T_OVERLOAD      = 1;
  localparam int T_RESTART       = 2;

endpackage

// [logic/pcr_port_config_regs.sv]
`timescale 1ns/1ns
// Function
// - bit 15 skips detection, powers up
// - bit 14 ends classification, self clears
// - bit 13 enters classification mode
// - bits 12,11 kill pull-up, detection timer
// - bit 10 stops foldback during inrush
// - bit 9 stops soft-start during inrush
// - bit 8 stops discharge time-out timer
// - bit 7 stops signature dropout timer
// - bits 4,3 block pd, source wake-up
// - bit 2 wakes the port
// - bit 1 low ignores auto-enable pin
// - bit 0 enables port by software
// - timer bit 8 fakes valid wake signature
// - bits 7:6 pick fault period
// - fault timer falls eight times faster
// - bits 5:4 pick overload, restart times
// - bits 3:2 pick inrush period
// - bits 1,0 force bad, good signature
// - result stored with new, missed flags
module pcr_port_config_regs #(
  parameter int FAULT_US_0   = pcr_pkg::FAULT_PERIOD_0_US,
  parameter int FAULT_US_1   = pcr_pkg::FAULT_PERIOD_1_US,
  parameter int FAULT_US_2   = pcr_pkg::FAULT_PERIOD_2_US,
  parameter int FAULT_US_3   = pcr_pkg::FAULT_PERIOD_3_US,
  parameter int INRUSH_US_0  = pcr_pkg::INRUSH_PERIOD_0_US,
  parameter int INRUSH_US_1  = pcr_pkg::INRUSH_PERIOD_1_US,
  parameter int INRUSH_US_2  = pcr_pkg::INRUSH_PERIOD_2_US,
  parameter int OVERLOAD_US  = pcr_pkg::OVERLOAD_DELAY_US,
  parameter int RESTART_US   = pcr_pkg::RESTART_DELAY_US,
  parameter int TICK_CYCLES  = pcr_pkg::TICK_DIV
) (
  input  wire logic        ref_clk,
  input  wire logic        rstn,
  input  wire logic [3:0]  reg_addr,
  input  wire logic        reg_wr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_rd,
  output logic      [15:0] reg_rdata,
  input  wire logic        auto_pin,
  input  wire logic        fault_present,
  input  wire logic        inrush_active,
  input  wire logic        overload_active,
  input  wire logic        restart_active,
  input  wire logic        adc_valid,
  input  wire logic [11:0] adc_data,
  output logic             port_enable,
  output logic             force_power_up,
  output logic             end_classification,
  output logic             set_class_mode,
  output logic             pullup_off,
  output logic             det_timer_off,
  output logic             foldback_off,
  output logic             softstart_off,
  output logic             discharge_timer_off,
  output logic             dropout_timer_off,
  output logic             ready_for_detect,
  output logic             power_avail,
  output logic             pd_wake_block,
  output logic             src_wake_block,
  output logic             wake_request,
  output logic             force_wake_sig_good,
  output logic             force_sig_bad,
  output logic             force_sig_good,
  output logic      [7:0]  hold_sig_threshold,
  output logic             fault_expired,
  output logic             inrush_done,
  output logic             overload_done,
  output logic             restart_done
);

  typedef logic [pcr_pkg::TIMER_W-1:0] pcr_cnt_t;

  typedef struct packed {
    logic [15:0]                             ctl;
    logic [pcr_pkg::TMR_USED_W-1:0]          tmr;
    logic [pcr_pkg::THR_W-1:0]               thr;
    logic [pcr_pkg::RES_DATA_W-1:0]          res;
    logic                                    res_new;
    logic                                    res_missed;
    logic [15:0]                             rdata;
    logic [6:0]                              div;
    logic                                    tick;
    pcr_cnt_t                                flt;
    logic                                    flt_exp;
    logic [pcr_pkg::NUM_TIMERS-1:0][pcr_pkg::TIMER_W-1:0] cnt;
    logic [pcr_pkg::NUM_TIMERS-1:0]          done;
  } pcr_state_t;

  localparam pcr_state_t STATE_RST = '{
    ctl:        pcr_pkg::CONTROL_RST,
    tmr:        pcr_pkg::TIMER_RST,
    thr:        pcr_pkg::THRESHOLD_RST,
    res:        '0,
    res_new:    1'b0,
    res_missed: 1'b0,
    rdata:      '0,
    div:        '0,
    tick:       1'b0,
    flt:        pcr_cnt_t'(FAULT_US_0),
    flt_exp:    1'b0,
    cnt:        '0,
    done:       '0
  };

  pcr_state_t st;
  pcr_state_t next_st;

  logic [1:0] fault_sel;
  logic [1:0] ovld_sel;
  logic [1:0] inrush_sel;
  pcr_cnt_t   fault_top;
  pcr_cnt_t   limit [pcr_pkg::NUM_TIMERS];
  logic       forever_sel [pcr_pkg::NUM_TIMERS];
  logic       active [pcr_pkg::NUM_TIMERS];
  logic       wr_ctl;
  logic       wr_tmr;
  logic       wr_thr;
  logic       rd_res;

  // selector fields and access strobes
  assign fault_sel  = st.tmr[pcr_pkg::TMR_FAULT_LSB +: 2];
  assign ovld_sel   = st.tmr[pcr_pkg::TMR_OVLD_LSB +: 2];
  assign inrush_sel = st.tmr[pcr_pkg::TMR_INRUSH_LSB +: 2];
  assign wr_ctl     = reg_wr && (reg_addr == pcr_pkg::ADDR_CONTROL_CONFIG);
  assign wr_tmr     = reg_wr && (reg_addr == pcr_pkg::ADDR_TIMER_CONFIG);
  assign wr_thr     = reg_wr && (reg_addr == pcr_pkg::ADDR_SIG_THRESHOLD);
  assign rd_res     = reg_rd && (reg_addr == pcr_pkg::ADDR_CURRENT_RESULT);

  // period selection in microsecond ticks
  always_comb begin
    case (fault_sel)
      2'h0:    fault_top = pcr_cnt_t'(FAULT_US_0);
      2'h1:    fault_top = pcr_cnt_t'(FAULT_US_1);
      2'h2:    fault_top = pcr_cnt_t'(FAULT_US_2);
      default: fault_top = pcr_cnt_t'(FAULT_US_3);
    endcase
    case (inrush_sel)
      2'h0:    limit[pcr_pkg::T_INRUSH] = pcr_cnt_t'(INRUSH_US_0);
      2'h1:    limit[pcr_pkg::T_INRUSH] = pcr_cnt_t'(INRUSH_US_1);
      default: limit[pcr_pkg::T_INRUSH] = pcr_cnt_t'(INRUSH_US_2);
    endcase
    // doubling by shift; code 11 never expires so its shift is unused
    limit[pcr_pkg::T_OVERLOAD] = pcr_cnt_t'(OVERLOAD_US) << ovld_sel;
    limit[pcr_pkg::T_RESTART]  = pcr_cnt_t'(RESTART_US) << ovld_sel;
    forever_sel[pcr_pkg::T_INRUSH]   = (inrush_sel == pcr_pkg::SEL_FOREVER);
    forever_sel[pcr_pkg::T_OVERLOAD] = (ovld_sel == pcr_pkg::SEL_FOREVER);
    forever_sel[pcr_pkg::T_RESTART]  = (ovld_sel == pcr_pkg::SEL_FOREVER);
    active[pcr_pkg::T_INRUSH]   = inrush_active;
    active[pcr_pkg::T_OVERLOAD] = overload_active;
    active[pcr_pkg::T_RESTART]  = restart_active;
  end

  // whole next state: register writes, result capture, timers
  always_comb begin
    next_st = st;

    // end-of-classification lasts one cycle unless rewritten
    next_st.ctl[pcr_pkg::CTL_END_CLASS] = 1'b0;
    if (wr_ctl) begin
      next_st.ctl = reg_wdata;
    end
    if (wr_tmr) begin
      next_st.tmr = reg_wdata[pcr_pkg::TMR_USED_W-1:0];
    end
    if (wr_thr) begin
      next_st.thr = reg_wdata[pcr_pkg::THR_W-1:0];
    end

    // reading the result clears flags; a new sample in the same cycle wins
    if (rd_res) begin
      next_st.res_new    = 1'b0;
      next_st.res_missed = 1'b0;
    end
    if (adc_valid) begin
      next_st.res     = adc_data;
      next_st.res_new = 1'b1;
      if (st.res_new && !rd_res) begin
        next_st.res_missed = 1'b1;
      end
    end

    // registered read data, unmapped indices read zero
    if (reg_rd) begin
      case (reg_addr)
        pcr_pkg::ADDR_CONTROL_CONFIG: next_st.rdata = st.ctl;
        pcr_pkg::ADDR_TIMER_CONFIG:   next_st.rdata = {7'h00, st.tmr};
        pcr_pkg::ADDR_SIG_THRESHOLD:  next_st.rdata = {8'h00, st.thr};
        pcr_pkg::ADDR_CURRENT_RESULT: next_st.rdata = {2'h0, st.res_missed, st.res_new, st.res};
        default:                      next_st.rdata = 16'h0000;
      endcase
    end

    // microsecond tick divider
    next_st.tick = 1'b0;
    if (st.div == 7'(TICK_CYCLES - 1)) begin
      next_st.div  = '0;
      next_st.tick = 1'b1;
    end else begin
      next_st.div = st.div + 7'h01;
    end

    // fault timer: falls by eight per tick under fault, rises by one otherwise
    next_st.flt_exp = 1'b0;
    if (st.flt > fault_top) begin
      next_st.flt = fault_top;
    end else if (st.tick) begin
      if (fault_present) begin
        if (st.flt <= pcr_cnt_t'(pcr_pkg::FAULT_DOWN_STEP)) begin
          next_st.flt     = '0;
          next_st.flt_exp = (st.flt != '0);
        end else begin
          next_st.flt = st.flt - pcr_cnt_t'(pcr_pkg::FAULT_DOWN_STEP);
        end
      end else if (st.flt < fault_top) begin
        next_st.flt = st.flt + pcr_cnt_t'(1);
      end
    end

    // inrush, overload and restart timers share one shape
    for (int i = 0; i < pcr_pkg::NUM_TIMERS; i++) begin
      next_st.done[i] = 1'b0;
      if (!active[i]) begin
        next_st.cnt[i] = '0;
      end else if (st.tick && !forever_sel[i] && (st.cnt[i] < limit[i])) begin
        next_st.cnt[i]  = st.cnt[i] + pcr_cnt_t'(1);
        next_st.done[i] = (st.cnt[i] + pcr_cnt_t'(1) == limit[i]);
      end
    end
  end

  // single state register
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      st <= STATE_RST;
    end else begin
      st <= next_st;
    end
  end

  // control outputs straight from the stored bits
  assign reg_rdata           = st.rdata;
  assign force_power_up      = st.ctl[pcr_pkg::CTL_FORCE_POWER_UP];
  assign end_classification  = st.ctl[pcr_pkg::CTL_END_CLASS];
  assign set_class_mode      = st.ctl[pcr_pkg::CTL_SET_CLASS];
  assign pullup_off          = st.ctl[pcr_pkg::CTL_PULLUP_OFF];
  assign det_timer_off       = st.ctl[pcr_pkg::CTL_DET_TIMER_OFF];
  assign discharge_timer_off = st.ctl[pcr_pkg::CTL_DISCHARGE_OFF];
  assign dropout_timer_off   = st.ctl[pcr_pkg::CTL_DROPOUT_OFF];
  assign ready_for_detect    = st.ctl[pcr_pkg::CTL_READY_DETECT];
  assign power_avail         = st.ctl[pcr_pkg::CTL_POWER_AVAIL];
  assign pd_wake_block       = st.ctl[pcr_pkg::CTL_PD_WAKE_BLOCK];
  assign src_wake_block      = st.ctl[pcr_pkg::CTL_SRC_WAKE_BLOCK];
  assign wake_request        = st.ctl[pcr_pkg::CTL_WAKE_REQUEST];
  assign force_wake_sig_good = st.tmr[pcr_pkg::TMR_FORCE_WAKE_GOOD];
  assign force_sig_bad       = st.tmr[pcr_pkg::TMR_SIG_BAD];
  assign force_sig_good      = st.tmr[pcr_pkg::TMR_SIG_GOOD];
  assign hold_sig_threshold  = st.thr;

  // inrush overrides only matter while inrush runs
  assign foldback_off  = st.ctl[pcr_pkg::CTL_FOLDBACK_OFF] && inrush_active;
  assign softstart_off = st.ctl[pcr_pkg::CTL_SOFTSTART_OFF] && inrush_active;

  // auto pin counts only when its gate bit is set
  assign port_enable = st.ctl[pcr_pkg::CTL_SW_ENABLE]
                       || (st.ctl[pcr_pkg::CTL_HW_PIN_GATE] && auto_pin);

  // expiry pulses
  assign fault_expired = st.flt_exp;
  assign inrush_done   = st.done[pcr_pkg::T_INRUSH];
  assign overload_done = st.done[pcr_pkg::T_OVERLOAD];
  assign restart_done  = st.done[pcr_pkg::T_RESTART];

  // checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);

  a_end_class_set: assert property (wr_ctl && reg_wdata[pcr_pkg::CTL_END_CLASS] |=> end_classification
    ) else $error("end classification not set by write");
  a_end_class_auto: assert property (end_classification && !wr_ctl |=> !end_classification)
    else $error("end classification did not self clear");
  a_force_power: assert property (wr_ctl |=>
    force_power_up == $past(reg_wdata[pcr_pkg::CTL_FORCE_POWER_UP]))
    else $error("force power up not stored");
  a_pin_masked: assert property (!st.ctl[pcr_pkg::CTL_HW_PIN_GATE] && !st.ctl[pcr_pkg::CTL_SW_ENABLE]
    |-> !port_enable) else $error("auto pin not masked");
  a_sw_enable: assert property (wr_ctl && reg_wdata[pcr_pkg::CTL_SW_ENABLE] |=> port_enable)
    else $error("software enable ignored");
  a_foldback_gate: assert property (!inrush_active |-> !foldback_off && !softstart_off)
    else $error("inrush override outside inrush");
  a_fault_down: assert property (st.tick && fault_present && st.flt > 24'h000008 && st.flt <= fault_top
    && !wr_tmr |=> st.flt == $past(st.flt) - 24'h000008) else $error("fault timer down step wrong");
  a_fault_up: assert property (st.tick && !fault_present && st.flt < fault_top && !wr_tmr
    |=> st.flt == $past(st.flt) + 24'h000001) else $error("fault timer up step wrong");
  a_adc_store: assert property (adc_valid |=> st.res == $past(adc_data) && st.res_new)
    else $error("adc result not stored");
  a_adc_missed: assert property (adc_valid && st.res_new && !rd_res |=> st.res_missed)
    else $error("missed flag not set");
  a_inrush_forever: assert property (inrush_sel == pcr_pkg::SEL_FOREVER && !wr_tmr
    |=> !inrush_done) else $error("forever inrush expired");
  a_reserved_zero: assert property (reg_rd && reg_addr == pcr_pkg::ADDR_TIMER_CONFIG
    |=> reg_rdata[15:9] == 7'h00) else $error("reserved bits not zero");
  a_tick_space: assert property (st.tick == ($past(st.div) == 7'(TICK_CYCLES - 1)))
    else $error("tick spacing wrong");

  // write-to-output paths of the plain level bits except force_power_up, ready_for_detect and power_avail,
  // then fault timer, forever overload and control readback checks
  a_class_mode: assert property (wr_ctl |=> set_class_mode == $past(reg_wdata[pcr_pkg::CTL_SET_CLASS]))
    else $error("class mode not stored");
  a_detect_bits: assert property (wr_ctl |=> pullup_off == $past(reg_wdata[pcr_pkg::CTL_PULLUP_OFF])
    && det_timer_off == $past(reg_wdata[pcr_pkg::CTL_DET_TIMER_OFF])) else $error("detection bits not stored");
  a_timer_off: assert property (wr_ctl |=>
    discharge_timer_off == $past(reg_wdata[pcr_pkg::CTL_DISCHARGE_OFF])
    && dropout_timer_off == $past(reg_wdata[pcr_pkg::CTL_DROPOUT_OFF])) else $error("time-out disables not stored");
  a_wake_blocks: assert property (wr_ctl |=>
    pd_wake_block == $past(reg_wdata[pcr_pkg::CTL_PD_WAKE_BLOCK])
    && src_wake_block == $past(reg_wdata[pcr_pkg::CTL_SRC_WAKE_BLOCK])) else $error("wake blocks not stored");
  a_wake_request: assert property (wr_ctl |=>
    wake_request == $past(reg_wdata[pcr_pkg::CTL_WAKE_REQUEST]))
    else $error("wake request not stored");
  a_sig_override: assert property (wr_tmr |=>
    force_wake_sig_good == $past(reg_wdata[pcr_pkg::TMR_FORCE_WAKE_GOOD])
    && force_sig_bad == $past(reg_wdata[pcr_pkg::TMR_SIG_BAD])
    && force_sig_good == $past(reg_wdata[pcr_pkg::TMR_SIG_GOOD])) else $error("signature overrides not stored");
  a_fault_clamp: assert property (st.flt > fault_top |=> st.flt == $past(fault_top))
    else $error("fault timer above selected top");
  a_ovld_forever: assert property (ovld_sel == pcr_pkg::SEL_FOREVER && !wr_tmr
    |=> !overload_done && !restart_done) else $error("forever overload expired");
  a_fault_zero: assert property (fault_expired |-> st.flt == '0)
    else $error("fault expiry with time left");
  a_ctl_readback: assert property (reg_rd && reg_addr == pcr_pkg::ADDR_CONTROL_CONFIG
    |=> reg_rdata == $past(st.ctl)) else $error("control readback wrong");

  c_missed: cover property (adc_valid && st.res_new && !rd_res);
  c_fault_exp: cover property (fault_expired);
  c_inrush_done: cover property (inrush_done);
  c_end_class: cover property (end_classification);
  c_read_sample: cover property (rd_res && adc_valid);

endmodule

// [test/pcr_host_model.sv]
`timescale 1ns/1ns
// host side of the register strobe port, driving on the falling edge
module pcr_host_model (
  input  wire logic        ref_clk,
  output logic      [3:0]  reg_addr,
  output logic             reg_wr,
  output logic      [15:0] reg_wdata,
  output logic             reg_rd,
  input  wire logic [15:0] reg_rdata
);
  // idle bus at time zero
  initial begin
    reg_addr  = 4'h0;
    reg_wr    = 1'b0;
    reg_wdata = 16'h0000;
    reg_rd    = 1'b0;
  end

  // one-cycle write; data inverted afterwards so a stale word never looks valid
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(negedge ref_clk);
    reg_addr  = a;
    reg_wdata = d;
    reg_wr    = 1'b1;
    @(negedge ref_clk);
    reg_wr    = 1'b0;
    reg_wdata = ~d;
  endtask

  // one-cycle read; data is registered, so taken one cycle after the strobe
  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(negedge ref_clk);
    reg_addr = a;
    reg_rd   = 1'b1;
    @(negedge ref_clk);
    d      = reg_rdata;
    reg_rd = 1'b0;
  endtask

  // bring-up: threshold code from the sense resistance, then detect and power flags
  task automatic setup(input real r_sense);
    logic [7:0] code;
    code = 8'(int'(62.5 * r_sense));
    wr(pcr_pkg::ADDR_SIG_THRESHOLD, {8'h00, code});
    wr(pcr_pkg::ADDR_CONTROL_CONFIG, 16'h0060);
  endtask
endmodule

// [test/testbench.sv]
`timescale 1ns/1ns
module testbench;
  localparam int TICK = 2;
  localparam int FLT [4] = '{40, 30, 20, 10};
  localparam int INR [3] = '{5, 10, 15};
  localparam int OVL = 20;
  localparam int RST = 10;
  logic        ref_clk, rstn, reg_wr, reg_rd, adc_valid;
  logic [3:0]  reg_addr;
  logic [15:0] reg_wdata, reg_rdata, r, w, t;
  logic [11:0] adc_data, d;
  logic        auto_pin, fault_present, inrush_active, overload_active, restart_active;
  logic        port_enable, force_power_up, end_classification, set_class_mode, pullup_off;
  logic        det_timer_off, foldback_off, softstart_off, discharge_timer_off, dropout_timer_off;
  logic        ready_for_detect, power_avail, pd_wake_block, src_wake_block, wake_request;
  logic        force_wake_sig_good, force_sig_bad, force_sig_good;
  logic [7:0]  hold_sig_threshold;
  logic        fault_expired, inrush_done, overload_done, restart_done;
  logic [15:0] ctl_obs;
  logic [3:0]  dones;
  int          n_errors, comparisons, cycles;

  // control outputs gathered at their bit positions; bit 1 has no output of its own
  assign ctl_obs = {force_power_up, end_classification, set_class_mode, pullup_off, det_timer_off,
                    foldback_off, softstart_off, discharge_timer_off, dropout_timer_off, ready_for_detect,
                    power_avail, pd_wake_block, src_wake_block, wake_request, 1'b0, port_enable};
  assign dones = {restart_done, overload_done, inrush_done, fault_expired};

  pcr_port_config_regs #(
    .FAULT_US_0(FLT[0]), .FAULT_US_1(FLT[1]), .FAULT_US_2(FLT[2]), .FAULT_US_3(FLT[3]),
    .INRUSH_US_0(INR[0]), .INRUSH_US_1(INR[1]), .INRUSH_US_2(INR[2]),
    .OVERLOAD_US(OVL), .RESTART_US(RST), .TICK_CYCLES(TICK)
  ) DUT (
    .ref_clk(ref_clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .auto_pin(auto_pin), .fault_present(fault_present),
    .inrush_active(inrush_active), .overload_active(overload_active), .restart_active(restart_active),
    .adc_valid(adc_valid), .adc_data(adc_data), .port_enable(port_enable), .force_power_up(force_power_up),
    .end_classification(end_classification), .set_class_mode(set_class_mode), .pullup_off(pullup_off),
    .det_timer_off(det_timer_off), .foldback_off(foldback_off), .softstart_off(softstart_off),
    .discharge_timer_off(discharge_timer_off), .dropout_timer_off(dropout_timer_off),
    .ready_for_detect(ready_for_detect), .power_avail(power_avail), .pd_wake_block(pd_wake_block),
    .src_wake_block(src_wake_block), .wake_request(wake_request), .force_wake_sig_good(force_wake_sig_good),
    .force_sig_bad(force_sig_bad), .force_sig_good(force_sig_good), .hold_sig_threshold(hold_sig_threshold),
    .fault_expired(fault_expired), .inrush_done(inrush_done), .overload_done(overload_done),
    .restart_done(restart_done)
  );

  pcr_host_model host (
    .ref_clk(ref_clk), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata)
  );

  // 100 MHz clock
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  // expected control outputs; foldback and soft-start only bite during inrush
  function automatic logic [15:0] ctl_exp(input logic [15:0] v, input logic inr, input logic pin);
    ctl_exp     = v;
    ctl_exp[10] = v[10] & inr;
    ctl_exp[9]  = v[9] & inr;
    ctl_exp[1]  = 1'b0;
    ctl_exp[0]  = v[0] | (v[1] & pin);
  endfunction

  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  // cycles until a done pulse; negative ticks means it must never come
  task automatic timed(input int idx, input int ticks, input string what);
    int n;
    n = 0;
    while (dones[idx] !== 1'b1 && n < 400) begin
      @(negedge ref_clk);
      n++;
    end
    comparisons++;
    if ((ticks < 0 && n < 400) || (ticks >= 0 && (n < ticks * TICK - 3 || n > ticks * TICK + 3))) begin
      n_errors++;
      $display("mismatch %s expected %0d seen %0d", what, ticks * TICK, n);
    end
  endtask

  task automatic adc(input logic [11:0] v);
    @(negedge ref_clk);
    adc_valid = 1'b1;
    adc_data  = v;
    @(negedge ref_clk);
    adc_valid = 1'b0;
    adc_data  = ~v;
  endtask

  task automatic end_of_test();
    $display("comparisons %0d n_errors %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // hang guard, far above the few thousand cycles the run needs
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_errors++;
      end_of_test();
    end
  end

  initial begin
    {rstn, adc_valid, auto_pin, fault_present, inrush_active, overload_active, restart_active} = 7'h00;
    adc_data = 12'h000;
    void'($urandom(14));
    repeat (12) @(negedge ref_clk);
    rstn = 1'b1;
    // reset values of the four registers
    for (int i = 0; i < 4; i++) begin
      host.rd(4'(3 + i), r);
      check("reset value", (i == 1) ? 16'h0008 : 16'h0000, r);
    end
    host.setup(1.6);
    check("threshold code", 16'h0064, {8'h00, hold_sig_threshold});
    check("bring-up flags", ctl_exp(16'h0060, 1'b0, 1'b0), ctl_obs);
    // control, timer and threshold words: control corners first, then random; timer and threshold random
    for (int i = 0; i < 16; i++) begin
      w = (i == 0) ? 16'hFFFF : (i == 1) ? 16'h4001 : (i == 2) ? 16'h0002 : 16'($urandom);
      inrush_active = (i == 0) ? 1'b1 : 1'($urandom);
      auto_pin = (i == 2) ? 1'b1 : 1'($urandom);
      host.wr(pcr_pkg::ADDR_CONTROL_CONFIG, w);
      check("control outputs", ctl_exp(w, inrush_active, auto_pin), ctl_obs);
      @(negedge ref_clk);
      check("control after pulse", ctl_exp(w & 16'hBFFF, inrush_active, auto_pin), ctl_obs);
      host.rd(pcr_pkg::ADDR_CONTROL_CONFIG, r);
      check("control readback", w & 16'hBFFF, r);
      t = 16'($urandom);
      host.wr(pcr_pkg::ADDR_TIMER_CONFIG, t);
      check("override outputs", {13'h0000, t[8], t[1], t[0]},
            {13'h0000, force_wake_sig_good, force_sig_bad, force_sig_good});
      host.rd(pcr_pkg::ADDR_TIMER_CONFIG, r);
      check("timer readback", t & 16'h01FF, r);
      host.wr(pcr_pkg::ADDR_SIG_THRESHOLD, ~t);
      host.rd(pcr_pkg::ADDR_SIG_THRESHOLD, r);
      check("threshold readback", ~t & 16'h00FF, r);
      check("threshold output", ~t & 16'h00FF, {8'h00, hold_sig_threshold});
    end
    inrush_active = 1'b0;
    // inrush, overload and restart for every selector code
    for (int c = 0; c < 4; c++) begin
      host.wr(pcr_pkg::ADDR_TIMER_CONFIG, 16'(c * 20));
      inrush_active = 1'b1;
      timed(1, (c == 3) ? -1 : INR[c % 3], "inrush period");
      inrush_active = 1'b0;
      overload_active = 1'b1;
      timed(2, (c == 3) ? -1 : OVL << c, "overload delay");
      overload_active = 1'b0;
      restart_active = 1'b1;
      timed(3, (c == 3) ? -1 : RST << c, "restart delay");
      restart_active = 1'b0;
    end
    // fault period per code, then a partial refill at the slow rate
    for (int k = 0; k < 4; k++) begin
      host.wr(pcr_pkg::ADDR_TIMER_CONFIG, 16'(k << 6));
      repeat (100) @(negedge ref_clk);
      fault_present = 1'b1;
      timed(0, (FLT[k] + 7) / 8, "fault period");
      fault_present = 1'b0;
      repeat (26) @(negedge ref_clk);
      fault_present = 1'b1;
      timed(0, 2, "fault recovery");
      fault_present = 1'b0;
    end
    // source-current results: new flag, clear on read, missed on overwrite
    d = 12'($urandom);
    adc(d);
    host.rd(pcr_pkg::ADDR_CURRENT_RESULT, r);
    check("result new", {4'h1, d}, r);
    host.rd(pcr_pkg::ADDR_CURRENT_RESULT, r);
    check("result cleared", {4'h0, d}, r);
    adc(d);
    adc(~d);
    host.rd(pcr_pkg::ADDR_CURRENT_RESULT, r);
    check("result missed", {4'h3, ~d}, r);
    host.wr(pcr_pkg::ADDR_CURRENT_RESULT, 16'hFFFF);
    host.rd(pcr_pkg::ADDR_CURRENT_RESULT, r);
    check("result write ignored", {4'h0, ~d}, r);
    // a sample landing with the read: old word returned, new flag survives
    adc(d);
    fork
      adc(~d);
      host.rd(pcr_pkg::ADDR_CURRENT_RESULT, r);
    join
    check("result read during sample", {4'h1, d}, r);
    host.rd(pcr_pkg::ADDR_CURRENT_RESULT, r);
    check("result kept new", {4'h1, ~d}, r);
    host.wr(4'h0, 16'hFFFF);
    host.rd(4'h0, r);
    check("unmapped read", 16'h0000, r);
    end_of_test();
  end
endmodule
